// ===== hw/eoc_pkg.sv
// Constants shared by the external oscillator control block
//
// Functional notes
// - Oscillator control writes land only with write protect off and PLL clock select set.
// - Each accepted oscillator control write clears the oscillator stable flag, and the PLL lock flag unless a new lock arrives in the same cycle.
// - Bit 7 is the external oscillator enable: one starts the oscillator, zero stops it.
// - With the enable at zero the PLL reference comes from the internal RC clock.
// - Enable at one runs the clock monitor; PLL reference is oscillator clock over the divider.
// - Once the enabled oscillator has first been stable, loss of oscillation raises a clock monitor reset; loss during startup does not.
// - Stable flag sets once oscillation is steady; only then may bus, watchdog or timer use it.
// - Bit 5 is a read-only pin reservation flag, set while enable is one, cleared only by reset.
// - While reserved, both crystal pins serve the oscillator alone, withheld from other uses.
package eoc_pkg;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [9:0]  OSC_CTRL_IDX  = 10'h2FA;
  localparam logic [9:0]  CLK_CTRL_IDX  = 10'h2F0;
  localparam logic [9:0]  CLK_FLAG_IDX  = 10'h2F1;
  localparam logic [9:0]  IRQ_STAT_IDX  = 10'h2F2;
  localparam logic [9:0]  IRQ_MASK_IDX  = 10'h2F3;
  localparam logic [11:0] OSC_CTRL_ADDR = {OSC_CTRL_IDX, 2'h0};
  localparam logic [11:0] CLK_CTRL_ADDR = {CLK_CTRL_IDX, 2'h0};
  localparam logic [11:0] CLK_FLAG_ADDR = {CLK_FLAG_IDX, 2'h0};
  localparam logic [11:0] IRQ_STAT_ADDR = {IRQ_STAT_IDX, 2'h0};
  localparam logic [11:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'h0};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int OSC_EN_BIT  = 7;
  localparam int RSV_HI_BIT  = 6;
  localparam int PINS_BIT    = 5;
  localparam int GUARD_BIT   = 0;
  localparam int PLL_SEL_BIT = 1;
  localparam int BUSEXT_BIT  = 2;
  localparam int WDOGEXT_BIT = 3;
  localparam int PITEXT_BIT  = 4;
  localparam int REF_DIV_LSB = 8;
  localparam int CTRL_W      = 12;
  localparam int EVT_W       = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [CTRL_W-1:0] CLK_CTRL_RST = 12'h002;
  localparam logic [5:0]        OSC_RSV_RST  = 6'h00;
  localparam logic [EVT_W-1:0]  IRQ_MASK_RST = 3'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          OSC_STARTUP_NS = 100000;
  localparam logic [11:0] STARTUP_CYC    =
    12'((OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// ===== hw/eoc_sync2.sv
// Two flip-flop synchroniser for levels entering the bus clock domain
`timescale 1ns/100ps
module eoc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

// ===== hw/eoc_top.sv
// External oscillator control with APB register access
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module eoc_top
  import eoc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        OSC_ACTIVE,
  input  wire logic        PLL_LOCKED,
  input  wire logic        CRYSTAL_IN_PIN_I,
  output logic             CRYSTAL_IN_PIN_O,
  output logic             CRYSTAL_IN_PIN_OE,
  input  wire logic        CRYSTAL_OUT_PIN_I,
  output logic             CRYSTAL_OUT_PIN_O,
  output logic             CRYSTAL_OUT_PIN_OE,
  input  wire logic        GPIO_XIN_O,
  input  wire logic        GPIO_XIN_OE,
  output logic             GPIO_XIN_I,
  input  wire logic        GPIO_XOUT_O,
  input  wire logic        GPIO_XOUT_OE,
  output logic             GPIO_XOUT_I,
  output logic             OSC_EN,
  output logic             PLL_REF_SEL_EXT,
  output logic      [3:0]  REF_DIV,
  output logic      [5:0]  PLL_TRIM,
  output logic             CLKMON_EN,
  output logic             CLKMON_RESET,
  output logic             PINS_RESERVED,
  output logic             BUS_CLK_SEL_EXT,
  output logic             WDOG_SRC_EXT,
  output logic             PIT_SRC_EXT,
  output logic             IRQ
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [3:0]        sync_q;
  logic              active_s;
  logic              lock_s;
  logic              xin_s;
  logic              xout_s;
  logic              setup_ph;
  logic              access_ph;
  logic              bus_wr;
  logic              rd_setup;
  logic              hit_osc;
  logic              hit_clk;
  logic              hit_flag;
  logic              hit_stat;
  logic              hit_mask;
  logic              hit_any;
  logic              osc_wr_req;
  logic              osc_wr_ok;
  logic              clk_wr;
  logic              guard_on;
  logic [7:0]        osc_rd;
  logic [31:0]       rd_mux;
  logic              en_reg;
  logic              en_next;
  logic [5:0]        rsv_reg;
  logic [5:0]        rsv_next;
  logic              pins_reg;
  logic              pins_next;
  logic [CTRL_W-1:0] clk_ctrl_reg;
  logic [CTRL_W-1:0] clk_ctrl_next;
  logic [11:0]       cnt_reg;
  logic [11:0]       cnt_next;
  logic              stable_reg;
  logic              stable_next;
  logic              stable_rise;
  logic              armed_reg;
  logic              armed_next;
  logic              loss;
  logic              cmr_reg;
  logic              lock_d_reg;
  logic              lock_rise;
  logic              lock_reg;
  logic              lock_next;
  logic [EVT_W-1:0]  events;
  logic [EVT_W-1:0]  stat_reg;
  logic [EVT_W-1:0]  stat_next;
  logic [EVT_W-1:0]  stat_w1c;
  logic [EVT_W-1:0]  mask_reg;
  logic [EVT_W-1:0]  mask_next;
  logic [31:0]       prdata_reg;
  logic [31:0]       prdata_next;

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  // Oscillator cell and PLL report from analog domains
  eoc_sync2 #(
    .W (4)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({OSC_ACTIVE, PLL_LOCKED, CRYSTAL_IN_PIN_I, CRYSTAL_OUT_PIN_I}),
    .q     (sync_q)
  );

  assign active_s = sync_q[3];
  assign lock_s   = sync_q[2];
  assign xin_s    = sync_q[1];
  assign xout_s   = sync_q[0];

  // ************************************************************
  // APB decode
  // ************************************************************
  assign setup_ph   = PSEL & ~PENABLE;
  assign access_ph  = PSEL & PENABLE;
  assign bus_wr     = access_ph & PWRITE;
  assign rd_setup   = setup_ph & ~PWRITE;
  assign hit_osc    = (PADDR == OSC_CTRL_ADDR);
  assign hit_clk    = (PADDR == CLK_CTRL_ADDR);
  assign hit_flag   = (PADDR == CLK_FLAG_ADDR);
  assign hit_stat   = (PADDR == IRQ_STAT_ADDR);
  assign hit_mask   = (PADDR == IRQ_MASK_ADDR);
  assign hit_any    = hit_osc | hit_clk | hit_flag | hit_stat | hit_mask;
  assign PREADY     = 1'b1;
  assign PSLVERR    = access_ph & ~hit_any;
  assign guard_on   = clk_ctrl_reg[GUARD_BIT];
  assign osc_wr_req = bus_wr & hit_osc;
  assign osc_wr_ok  = osc_wr_req & ~guard_on & clk_ctrl_reg[PLL_SEL_BIT];
  assign clk_wr     = bus_wr & hit_clk;

  // ************************************************************
  // Read path
  // ************************************************************
  // Readable at any time, reserved bits as held
  assign osc_rd = {en_reg, rsv_reg[5], pins_reg, rsv_reg[4:0]};
  assign rd_mux = hit_osc  ? {24'h000000, osc_rd} :
                  hit_clk  ? {20'h00000, clk_ctrl_reg} :
                  hit_flag ? {29'h00000000, active_s, lock_reg, stable_reg} :
                  hit_stat ? {29'h00000000, stat_reg} :
                  hit_mask ? {29'h00000000, mask_reg} :
                  32'h00000000;
  // Sampled in setup so PRDATA comes straight from a flop
  assign prdata_next = rd_setup ? rd_mux : prdata_reg;
  assign PRDATA      = prdata_reg;

  // ************************************************************
  // Oscillator control register
  // ************************************************************
  assign en_next   = osc_wr_ok ? PWDATA[OSC_EN_BIT] : en_reg;
  // Reserved bits stored as written; software keeps them
  assign rsv_next  = osc_wr_ok ? {PWDATA[RSV_HI_BIT], PWDATA[4:0]} : rsv_reg;
  // Sticky until reset, no write path
  assign pins_next = pins_reg | en_reg;

  // Divider and source selects obey the protect bit
  always_comb begin
    clk_ctrl_next = clk_ctrl_reg;
    if (clk_wr) begin
      clk_ctrl_next[GUARD_BIT] = PWDATA[GUARD_BIT];
      if (!guard_on) begin
        clk_ctrl_next[CTRL_W-1:1] = PWDATA[CTRL_W-1:1];
      end
    end
  end

  // ************************************************************
  // Startup qualification and clock monitor
  // ************************************************************
  // Count restarts on any accepted write, so a stale stable never survives
  always_comb begin
    cnt_next = cnt_reg;
    if (osc_wr_ok || !en_reg || !active_s) begin
      cnt_next = 12'h000;
    end else if (cnt_reg != STARTUP_CYC) begin
      cnt_next = cnt_reg + 12'h001;
    end
  end

  assign stable_next = (cnt_next == STARTUP_CYC);
  assign stable_rise = stable_next & ~stable_reg;
  // Monitor armed only after first stable, so startup is not a loss
  assign loss        = en_reg & armed_reg & ~active_s;
  assign armed_next  = en_reg & ~loss & (armed_reg | stable_next);

  // ************************************************************
  // PLL lock flag
  // ************************************************************
  assign lock_rise = lock_s & ~lock_d_reg;
  // New lock beats a clearing write in the same cycle
  assign lock_next = lock_rise | (lock_reg & ~osc_wr_ok);

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  assign events    = {loss, lock_rise, stable_rise};
  assign stat_w1c  = (bus_wr & hit_stat) ? PWDATA[EVT_W-1:0] : 3'h0;
  assign stat_next = (stat_reg & ~stat_w1c) | events;
  assign mask_next = (bus_wr & hit_mask) ? PWDATA[EVT_W-1:0] : mask_reg;
  assign IRQ       = |(stat_reg & mask_reg);

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      en_reg       <= 1'b0;
      rsv_reg      <= OSC_RSV_RST;
      pins_reg     <= 1'b0;
      clk_ctrl_reg <= CLK_CTRL_RST;
      prdata_reg   <= 32'h00000000;
    end else begin
      en_reg       <= en_next;
      rsv_reg      <= rsv_next;
      pins_reg     <= pins_next;
      clk_ctrl_reg <= clk_ctrl_next;
      prdata_reg   <= prdata_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt_reg    <= 12'h000;
      stable_reg <= 1'b0;
      armed_reg  <= 1'b0;
      cmr_reg    <= 1'b0;
    end else begin
      cnt_reg    <= cnt_next;
      stable_reg <= stable_next;
      armed_reg  <= armed_next;
      cmr_reg    <= loss;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      lock_d_reg <= 1'b0;
      lock_reg   <= 1'b0;
      stat_reg   <= 3'h0;
      mask_reg   <= IRQ_MASK_RST;
    end else begin
      lock_d_reg <= lock_s;
      lock_reg   <= lock_next;
      stat_reg   <= stat_next;
      mask_reg   <= mask_next;
    end
  end

  // ************************************************************
  // Clock steering outputs
  // ************************************************************
  assign OSC_EN          = en_reg;
  assign PLL_TRIM        = rsv_reg;
  assign PLL_REF_SEL_EXT = en_reg;
  assign CLKMON_EN       = en_reg;
  assign REF_DIV         = clk_ctrl_reg[REF_DIV_LSB+3:REF_DIV_LSB];
  assign CLKMON_RESET    = cmr_reg;
  assign PINS_RESERVED   = pins_reg;
  // Requests wait for stable; a cleared flag drops the oscillator at once
  assign BUS_CLK_SEL_EXT = clk_ctrl_reg[BUSEXT_BIT] & stable_reg;
  assign WDOG_SRC_EXT    = clk_ctrl_reg[WDOGEXT_BIT] & stable_reg;
  assign PIT_SRC_EXT     = clk_ctrl_reg[PITEXT_BIT] & stable_reg;

  // ************************************************************
  // Crystal pin sharing
  // ************************************************************
  // Port logic loses both pins, output and input, until reset
  assign CRYSTAL_IN_PIN_O   = GPIO_XIN_O & ~pins_reg;
  assign CRYSTAL_IN_PIN_OE  = GPIO_XIN_OE & ~pins_reg;
  assign CRYSTAL_OUT_PIN_O  = GPIO_XOUT_O & ~pins_reg;
  assign CRYSTAL_OUT_PIN_OE = GPIO_XOUT_OE & ~pins_reg;
  assign GPIO_XIN_I         = xin_s & ~pins_reg;
  assign GPIO_XOUT_I        = xout_s & ~pins_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_loss_pulse;
    CLKMON_RESET ##1 !CLKMON_RESET;
  endsequence

  sequence s_armed_loss;
    OSC_EN && armed_reg && !active_s;
  endsequence

  chk_write_gate: assert property (
    osc_wr_req && (guard_on || !clk_ctrl_reg[PLL_SEL_BIT])
      |=> $stable(OSC_EN) && $stable(PLL_TRIM))
    else $error("Blocked oscillator write changed the register");

  chk_write_clears: assert property (
    osc_wr_ok && !lock_rise |=> !stable_reg && !lock_reg && cnt_reg == 12'h000)
    else $error("Accepted write did not clear the status flags");

  chk_enable_bit: assert property (
    osc_wr_ok |=> OSC_EN == $past(PWDATA[OSC_EN_BIT]))
    else $error("Enable bit does not follow the accepted write");

  chk_ref_internal: assert property (
    $fell(OSC_EN) |-> !PLL_REF_SEL_EXT && !CLKMON_EN)
    else $error("PLL reference not internal with oscillator off");

  chk_ref_external: assert property (
    $rose(OSC_EN) |-> PLL_REF_SEL_EXT && CLKMON_EN
      && REF_DIV == clk_ctrl_reg[REF_DIV_LSB+3:REF_DIV_LSB])
    else $error("PLL reference or monitor wrong with oscillator on");

  chk_loss_reset: assert property (
    s_armed_loss |=> s_loss_pulse)
    else $error("Oscillation loss gave no single reset pulse");

  chk_stable_delay: assert property (
    $rose(stable_reg) |-> $past(cnt_reg) == STARTUP_CYC - 12'h001 && OSC_EN)
    else $error("Stable flag set before the startup count ran out");

  chk_sel_gated: assert property (
    BUS_CLK_SEL_EXT || WDOG_SRC_EXT || PIT_SRC_EXT |-> stable_reg && OSC_EN)
    else $error("Oscillator selected as source before it was stable");

  chk_pins_sticky: assert property (
    PINS_RESERVED || OSC_EN |=> PINS_RESERVED)
    else $error("Pin reservation flag missing or cleared without reset");

  chk_pins_withheld: assert property (
    PINS_RESERVED |-> !CRYSTAL_IN_PIN_OE && !CRYSTAL_OUT_PIN_OE
      && !GPIO_XIN_I && !GPIO_XOUT_I)
    else $error("Reserved crystal pin still reachable by port logic");

  chk_read_any: assert property (
    rd_setup && hit_osc |=> PRDATA[OSC_EN_BIT] == $past(OSC_EN)
      && PRDATA[PINS_BIT] == $past(PINS_RESERVED) && PRDATA[31:8] == 24'h000000)
    else $error("Oscillator control read returned wrong data");

endmodule

// ===== tb/eoc_crystal_out_pin_model.sv
// Behavioural crystal circuit on the far side of the oscillator control
`timescale 1ns/100ps
module eoc_crystal_model #(
  parameter int START_CYC = 16
) (
  input  wire logic clk,
  input  wire logic osc_en,
  input  wire logic lose,
  output logic      osc_active,
  output logic      crystal_wave
);
  int cnt = 0;
  // ************************************************************
  // Startup and oscillation
  // ************************************************************
  // Amplitude builds only while enabled; a loss drops it at once
  always @(posedge clk) begin
    if (!osc_en || lose) begin
      cnt <= 0;
    end else if (cnt < START_CYC) begin
      cnt <= cnt + 1;
    end
  end
  assign osc_active = osc_en && !lose && (cnt == START_CYC);
  // Pin swings only while oscillating, else rests at the pull-up
  always @(posedge clk) begin
    crystal_wave <= osc_active ? !crystal_wave : 1'b1;
  end
endmodule

// ===== tb/tb.sv
// Self-checking testbench for the external oscillator control block
`timescale 1ns/100ps
module tb
  import eoc_pkg::*;
;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pll_locked = 0, lose = 0, gx_o = 1, gx_oe = 1, go_o = 1, go_oe = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rv;
  logic        ev;
  wire  [31:0] prdata;
  wire  [3:0]  ref_div;
  wire  [5:0]  trim;
  wire         pready, pslverr, cin_o, cin_oe, cout_o, cout_oe, gxi, goi;
  wire         osc_en, ref_ext, mon_en, mon_rst, pins, bus_x, wd_x, pit_x, irq;
  wire         osc_act, xwave;
  int          err_total = 0, cmp_count = 0, pulses = 0, cyc = 0, t0, i;
  // Pin level resolved from the pad driver and the crystal swing
  wire xin_lvl  = cin_oe ? cin_o : xwave;
  wire xout_lvl = cout_oe ? cout_o : xwave;

  always #20 clk = !clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (mon_rst === 1'b1) pulses <= pulses + 1;

  eoc_top uut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .OSC_ACTIVE(osc_act), .PLL_LOCKED(pll_locked),
    .CRYSTAL_IN_PIN_I(xin_lvl), .CRYSTAL_IN_PIN_O(cin_o), .CRYSTAL_IN_PIN_OE(cin_oe),
    .CRYSTAL_OUT_PIN_I(xout_lvl), .CRYSTAL_OUT_PIN_O(cout_o),
    .CRYSTAL_OUT_PIN_OE(cout_oe), .GPIO_XIN_O(gx_o), .GPIO_XIN_OE(gx_oe),
    .GPIO_XIN_I(gxi), .GPIO_XOUT_O(go_o), .GPIO_XOUT_OE(go_oe), .GPIO_XOUT_I(goi),
    .OSC_EN(osc_en), .PLL_REF_SEL_EXT(ref_ext), .REF_DIV(ref_div), .PLL_TRIM(trim),
    .CLKMON_EN(mon_en), .CLKMON_RESET(mon_rst), .PINS_RESERVED(pins),
    .BUS_CLK_SEL_EXT(bus_x), .WDOG_SRC_EXT(wd_x), .PIT_SRC_EXT(pit_x), .IRQ(irq)
  );

  eoc_crystal_model #(.START_CYC(16)) u_crystal (
    .clk(clk), .osc_en(osc_en), .lose(lose), .osc_active(osc_act), .crystal_wave(xwave)
  );

  // ************************************************************
  // Bus tasks and compare
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rv);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Polls the flag register; each poll spans three cycles
  task automatic wait_stable();
    for (i = 0; i < 1500; i++) begin
      apb(1'b0, CLK_FLAG_ADDR, 32'h0);
      if (rv[0] === 1'b1) break;
    end
    chk("stable flag", 32'h1, {31'h0, rv[0]});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle(4);
    chk("osc_en rst", 32'h0, osc_en);
    chk("ref sel rst", 32'h0, ref_ext);
    chk("pin oe free", 32'h1, cin_oe);
    chk("gpio in free", 32'h1, gxi);
    chk("gpio out free", 32'h1, goi);
    chk("xin drv free", 32'h1, cin_o);
    chk("xout drv free", 32'h1, cout_o);
    rd("osc ctrl rst", OSC_CTRL_ADDR, 32'h0);
    $display("test reset done");
    wr(CLK_CTRL_ADDR, 32'h3);
    wr(OSC_CTRL_ADDR, 32'h80);
    rd("osc protected", OSC_CTRL_ADDR, 32'h0);
    wr(CLK_CTRL_ADDR, 32'h0);
    rd("clk unguarded", CLK_CTRL_ADDR, 32'h2);
    wr(CLK_CTRL_ADDR, 32'h0);
    wr(OSC_CTRL_ADDR, 32'h80);
    rd("osc no pll_clock_select", OSC_CTRL_ADDR, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped err", 32'h1, ev);
    chk("unmapped data", 32'h0, rv);
    $display("test protect done");
    wr(CLK_CTRL_ADDR, 32'h31E);
    wr(IRQ_MASK_ADDR, 32'h7);
    rd("irq mask", IRQ_MASK_ADDR, 32'h7);
    wr(OSC_CTRL_ADDR, 32'h80);
    t0 = cyc;
    settle(2);
    chk("osc_en", 32'h1, osc_en);
    chk("ref sel ext", 32'h1, ref_ext);
    chk("mon en", 32'h1, mon_en);
    chk("ref div", 32'h3, ref_div);
    chk("trim", 32'h0, trim);
    chk("pins", 32'h1, pins);
    chk("xin oe", 32'h0, cin_oe);
    chk("xout oe", 32'h0, cout_oe);
    chk("xin drv held", 32'h0, cin_o);
    chk("xout drv held", 32'h0, cout_o);
    chk("bus sel early", 32'h0, bus_x);
    rd("osc ctrl en", OSC_CTRL_ADDR, 32'hA0);
    chk("gpio in held", 32'h0, gxi);
    chk("gpio out held", 32'h0, goi);
    wait_stable();
    chk("startup span", 32'h1, (cyc - t0) >= int'(STARTUP_CYC));
    settle(1);
    chk("src sel", 32'h7, {bus_x, wd_x, pit_x});
    chk("irq stable", 32'h1, irq);
    rd("irq stat", IRQ_STAT_ADDR, 32'h1);
    wr(IRQ_STAT_ADDR, 32'h1);
    settle(1);
    chk("irq clr", 32'h0, irq);
    $display("test enable done");
    @(posedge clk);
    pll_locked <= 1'b1;
    settle(6);
    rd("flags locked", CLK_FLAG_ADDR, 32'h7);
    wr(OSC_CTRL_ADDR, 32'h80);
    rd("flags cleared", CLK_FLAG_ADDR, 32'h4);
    settle(1);
    chk("bus sel drop", 32'h0, bus_x);
    wait_stable();
    $display("test rewrite done");
    lose <= 1'b1;
    settle(8);
    chk("mon pulses", 32'h1, pulses);
    rd("irq loss", IRQ_STAT_ADDR, 32'h7);
    wr(IRQ_MASK_ADDR, 32'h0);
    settle(1);
    chk("irq masked", 32'h0, irq);
    wr(IRQ_STAT_ADDR, 32'h7);
    rd("irq w1c", IRQ_STAT_ADDR, 32'h0);
    $display("test loss done");
    wr(OSC_CTRL_ADDR, 32'h00);
    lose <= 1'b0;
    settle(2);
    chk("osc off", 32'h0, osc_en);
    chk("ref internal", 32'h0, ref_ext);
    chk("mon off", 32'h0, mon_en);
    chk("pins sticky", 32'h1, pins);
    chk("xin oe kept", 32'h0, cin_oe);
    rd("osc ctrl off", OSC_CTRL_ADDR, 32'h20);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    settle(4);
    chk("pins after rst", 32'h0, pins);
    chk("xin oe back", 32'h1, cin_oe);
    chk("gpio out back", 32'h1, goi);
    rd("osc ctrl rst2", OSC_CTRL_ADDR, 32'h0);
    $display("test disable done");
    results();
  end

  // Tests need roughly five thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    results();
  end
endmodule
